/* core/tpd_port.v */
/*
 * Eight-pin test point port: catches the strap on the low three pins as
 * reset releases, then drives the pins per the captured or reprogrammed
 * test mode (tri-state or clock debug outputs).
 * Assumes resetn is already synchronous to sys_clk; tp_in comes from pads
 * and is resynchronised here; sw_* inputs come from sys_clk logic.
 */
// What this block does
// - pins inputs in reset, outputs after release in mode 010 only
// - strap caught only on reset rising edge
// - later strap pin changes are ignored
// - weak pull-down on every pin
// - mode 000 keeps every pin tri-stated
// - mode 010 drives debug clocks and levels
// - only low three pins select the mode
// - software may reprogram selection after release
`timescale 1ns/1ps
`include "tpd_defs.vh"

module tpd_port (
    input  wire                     sys_clk,
    input  wire                     resetn,
    input  wire [`TPD_PIN_COUNT-1:0] tp_in,
    output reg  [`TPD_PIN_COUNT-1:0] tp_out,
    output reg  [`TPD_PIN_COUNT-1:0] tp_oe,
    output reg  [`TPD_PIN_COUNT-1:0] tp_pulldown_en,
    input  wire                     sw_mode_load,
    input  wire [`TPD_STRAP_W-1:0]  sw_mode,
    input  wire [`TPD_DIV_W-1:0]    sw_var_half,
    output reg  [`TPD_STRAP_W-1:0]  test_mode
);

    // half period in sys_clk cycles, rounded down, never below one
    function [`TPD_DIV_W-1:0] half_of;
        input integer hz;
        integer raw;
        begin
            raw = `TPD_SYS_CLK_HZ / (2 * hz);
            if (raw < 1)
                raw = 1;
            half_of = raw[`TPD_DIV_W-1:0];
        end
    endfunction

    // rates above sys_clk/2 cannot be made here; they clamp to one cycle
    localparam [`TPD_DIV_W-1:0] HALF_CLK0    = half_of(`TPD_CLK0_HZ);
    localparam [`TPD_DIV_W-1:0] HALF_CLK1    = half_of(`TPD_CLK1_HZ);
    localparam [`TPD_DIV_W-1:0] HALF_CLK7    = half_of(`TPD_CLK7_HZ);
    localparam [`TPD_DIV_W-1:0] HALF_VAR_MIN = half_of(`TPD_VAR_MAX_HZ);
    localparam [`TPD_DIV_W-1:0] HALF_VAR_MAX = half_of(`TPD_VAR_MIN_HZ);

    reg  [`TPD_PIN_COUNT-1:0] tp_meta;
    reg  [`TPD_PIN_COUNT-1:0] tp_sync;
    reg                       in_reset;
    reg  [`TPD_DIV_W-1:0]     var_half;
    reg  [`TPD_STRAP_W-1:0]   next_mode;
    reg  [`TPD_PIN_COUNT-1:0] next_oe;
    reg  [`TPD_PIN_COUNT-1:0] next_out;
    wire [`TPD_DIV_CHANNELS-1:0] div_clk;
    wire [`TPD_DIV_CHANNELS*`TPD_DIV_W-1:0] div_half;
    wire                      dbg_run;

    // pad synchroniser runs through reset so the strap is settled at release
    always @(posedge sys_clk) begin
        tp_meta <= tp_in;
        tp_sync <= tp_meta;
    end

    // software divisor for the variable clock, clamped to its legal band
    always @(posedge sys_clk) begin
        if (!resetn)
            var_half <= HALF_VAR_MAX;
        else if (sw_var_half < HALF_VAR_MIN)
            var_half <= HALF_VAR_MIN;
        else if (sw_var_half > HALF_VAR_MAX)
            var_half <= HALF_VAR_MAX;
        else
            var_half <= sw_var_half;
    end

    assign div_half = {var_half, HALF_CLK7, HALF_CLK1, HALF_CLK0};
    assign dbg_run  = (test_mode == `TPD_MODE_CLKDBG);

    genvar ch;
    generate
        for (ch = 0; ch < `TPD_DIV_CHANNELS; ch = ch + 1) begin : g_div
            tpd_clkdiv u_div (
                .sys_clk  (sys_clk),
                .resetn   (resetn),
                .run      (dbg_run),
                .half_cnt (div_half[ch*`TPD_DIV_W +: `TPD_DIV_W]),
                .div_clk  (div_clk[ch])
            );
        end
    endgenerate

    always @* begin
        if (in_reset)
            next_mode = tp_sync[`TPD_STRAP_W-1:0];
        else if (sw_mode_load)
            next_mode = sw_mode;
        else
            next_mode = test_mode;
        case (next_mode)
            `TPD_MODE_CLKDBG: begin
                next_oe  = `TPD_OE_ALL;
                next_out = `TPD_DBG_LEVELS;
                next_out[0] = div_clk[0];
                next_out[1] = div_clk[1];
                next_out[2] = div_clk[3];
                next_out[7] = div_clk[2];
            end
            default: begin
                // unlisted codes behave as the quiet mode
                next_oe  = `TPD_OE_NONE;
                next_out = {`TPD_PIN_COUNT{1'b0}};
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            in_reset       <= 1'b1;
            test_mode      <= `TPD_MODE_HIZ;
            tp_oe          <= `TPD_OE_NONE;
            tp_out         <= {`TPD_PIN_COUNT{1'b0}};
            tp_pulldown_en <= `TPD_PULLDOWN_ALL;
        end else begin
            in_reset       <= 1'b0;
            test_mode      <= next_mode;
            tp_oe          <= next_oe;
            tp_out         <= next_out;
            tp_pulldown_en <= `TPD_PULLDOWN_ALL;
        end
    end

endmodule

/* include/tpd_defs.vh */
/*
 * Constants for the test point strap and debug port: pin counts, strap
 * encodings, static debug levels and the clock figures from which the
 * divider half periods are derived.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TPD_DEFS_VH
`define TPD_DEFS_VH

`define TPD_PIN_COUNT      8
`define TPD_STRAP_W        3
`define TPD_DIV_W          8
`define TPD_DIV_CHANNELS   4

// strap encodings of the low three pins
`define TPD_MODE_HIZ       3'h0
`define TPD_MODE_CLKDBG    3'h2

// clock debug mode: pins 3, 5, 6 high, pin 4 low
`define TPD_DBG_LEVELS     8'h68
`define TPD_OE_NONE        8'h00
`define TPD_OE_ALL         8'hff
`define TPD_PULLDOWN_ALL   8'hff

// rates in Hz
`define TPD_SYS_CLK_HZ     25000000
`define TPD_CLK0_HZ        60000000
`define TPD_CLK1_HZ        30000000
`define TPD_CLK7_HZ        7500000
`define TPD_VAR_MIN_HZ     700000
`define TPD_VAR_MAX_HZ     22500000

`endif

/* core/tpd_clkdiv.v */
/*
 * Toggle divider: produces a square wave whose half period is half_cnt
 * cycles of sys_clk while run is high; held low otherwise.
 * Assumes half_cnt is at least one and stable from the same clock domain.
 */
`timescale 1ns/1ps
`include "tpd_defs.vh"

module tpd_clkdiv (
    input  wire                  sys_clk,
    input  wire                  resetn,
    input  wire                  run,
    input  wire [`TPD_DIV_W-1:0] half_cnt,
    output reg                   div_clk
);

    reg [`TPD_DIV_W-1:0] cnt;

    always @(posedge sys_clk) begin
        if (!resetn || !run) begin
            cnt     <= {`TPD_DIV_W{1'b0}};
            div_clk <= 1'b0;
        end else if (cnt + 8'h01 >= half_cnt) begin
            cnt     <= {`TPD_DIV_W{1'b0}};
            div_clk <= ~div_clk;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

endmodule

/* sim/tpd_jumpers.sv */
/* Board side of the test point pins: jumpers to pull-ups, else pull-down.
   Assumes pad output enables come straight from tpd_port. */
`timescale 1ns/1ps
module tpd_jumpers (
    input  wire [7:0] jumper,
    input  wire [7:0] tp_out,
    input  wire [7:0] tp_oe,
    output wire [7:0] tp_in
);
    // unjumpered undriven pins settle at the pull-down level
    assign tp_in = (tp_oe & tp_out) | (~tp_oe & jumper);
endmodule

/* sim/tpd_port_asserts.sv */
/* Concurrent checks on the tpd_port pins.
   Assumes binding to tpd_port; reset synchronous, active low. */
`timescale 1ns/1ps
module tpd_port_asserts (
    input wire       sys_clk,
    input wire       resetn,
    input wire [7:0] tp_in,
    input wire [7:0] tp_out,
    input wire [7:0] tp_oe,
    input wire [7:0] tp_pulldown_en,
    input wire       sw_mode_load,
    input wire [2:0] sw_mode,
    input wire [7:0] sw_var_half,
    input wire [2:0] test_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_strap; $rose(resetn) |=> test_mode == $past(tp_in[2:0], 3); endproperty
    a_strap: assert property (p_strap)
        else $error("strap not captured");
    property p_hold; !sw_mode_load && !$rose(resetn) |=> $stable(test_mode); endproperty
    a_hold: assert property (p_hold)
        else $error("mode moved without load");
    property p_load; sw_mode_load && !$rose(resetn) |=> test_mode == $past(sw_mode); endproperty
    a_load: assert property (p_load)
        else $error("software mode not taken");
    property p_hiz; test_mode != 3'h2 |-> tp_oe == 8'h00; endproperty
    a_hiz: assert property (p_hiz)
        else $error("pins driven outside debug mode");
    property p_dbg; test_mode == 3'h2 |-> tp_oe == 8'hff && (tp_out & 8'h78) == 8'h68; endproperty
    a_dbg: assert property (p_dbg)
        else $error("debug levels wrong");
    property p_pull; tp_pulldown_en == 8'hff; endproperty
    a_pull: assert property (p_pull)
        else $error("pull-down off");
    // a load in the last cycle may leave debug mode, so the pins legally fall
    property p_fast;
        (test_mode == 3'h2 && !sw_mode_load) [*4] |=> tp_out[1:0] == ~$past(tp_out[1:0]);
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast clocks stalled");
    property p_clk7; (test_mode == 3'h2 && !sw_mode_load) [*4] |=> $changed(tp_out[7]); endproperty
    a_clk7: assert property (p_clk7)
        else $error("pin 7 clock stalled");
endmodule
bind tpd_port tpd_port_asserts tpd_port_asserts_inst (.sys_clk(sys_clk), .resetn(resetn),
    .tp_in(tp_in), .tp_out(tp_out), .tp_oe(tp_oe), .tp_pulldown_en(tp_pulldown_en),
    .sw_mode_load(sw_mode_load), .sw_mode(sw_mode), .sw_var_half(sw_var_half),
    .test_mode(test_mode));

/* sim/tpd_port_tb_top.sv */
/* Bench for tpd_port: every strap, later pin changes, software loads.
   Assumes tpd_jumpers stands in for the board. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tpd_port_tb_top;
    reg        sys_clk = 0;
    reg        resetn = 0;
    reg        sw_mode_load = 0;
    reg  [2:0] sw_mode = 0;
    reg  [7:0] sw_var_half = 1;
    reg  [7:0] jumper = 0;
    wire [7:0] tp_in, tp_out, tp_oe, tp_pd;
    wire [2:0] test_mode;
    integer    miscompares = 0, checks_done = 0, exp_mode, i, b, n, exp_half;
    tpd_port tpd_port_inst (.sys_clk(sys_clk), .resetn(resetn), .tp_in(tp_in), .tp_out(tp_out),
        .tp_oe(tp_oe), .tp_pulldown_en(tp_pd), .sw_mode_load(sw_mode_load), .sw_mode(sw_mode),
        .sw_var_half(sw_var_half), .test_mode(test_mode));
    tpd_jumpers tpd_jumpers_inst (.jumper(jumper), .tp_out(tp_out), .tp_oe(tp_oe), .tp_in(tp_in));
    initial forever #20 sys_clk = ~sys_clk;
    task test_done;
        if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    task chk;
        #1;
        `CHK("test_mode", exp_mode[2:0], test_mode)
        `CHK("tp_oe", exp_mode == 2 ? 8'hff : 8'h00, tp_oe)
        `CHK("levels", exp_mode == 2 ? 8'h68 : 8'h00, tp_out & 8'h78)
        `CHK("pulldown", 8'hff, tp_pd)
    endtask
    initial begin
        cyc(4000);
        miscompares++;
        test_done;
    end
    initial begin
        i = $urandom(40420);
        cyc(2);
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            resetn <= 0;
            jumper <= {5'($urandom), i[2:0]};
            sw_var_half <= 8'($urandom % 24);
            cyc(3);
            `CHK("oe in reset", 8'h00, tp_oe)
            resetn <= 1;
            exp_mode = i % 8;
            cyc(1);
            chk;
            jumper <= 8'($urandom);
            cyc(6);
            chk;
            // pin 2 half period: requested divisor clamped to the 1..17 band
            exp_half = sw_var_half < 1 ? 1 : (sw_var_half > 17 ? 17 : sw_var_half);
            if (exp_mode == 2) begin
                b = tp_out[2];
                n = 0;
                while (tp_out[2] === b[0] && n < 40) begin
                    cyc(1);
                    #1;
                    n++;
                end
                b = tp_out[2];
                n = 0;
                while (tp_out[2] === b[0] && n < 40) begin
                    cyc(1);
                    #1;
                    n++;
                end
                `CHK("pin2 half", exp_half, n)
            end
            @(posedge sys_clk);
            sw_mode_load <= 1;
            sw_mode <= i[2:0] ^ 3'h2;
            b = $urandom % 8;
            @(posedge sys_clk);
            sw_mode <= b[2:0];
            exp_mode = i[2:0] ^ 3'h2;
            chk;
            @(posedge sys_clk);
            sw_mode_load <= 0;
            exp_mode = b;
            chk;
        end
        test_done;
    end
endmodule
